/* File: hw/sss_exec.sv */
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "sss_map.svh"

module sss_exec (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // core status
  output logic             halted,
  output logic             osc_run
);
  import sss_pkg::*;

  sss_regs_type r_q;
  sss_regs_type r_d;

  sss_op_type  alu_op;
  logic [7:0]  alu_file;
  logic [7:0]  alu_result;
  logic        alu_carry;
  logic        alu_digit;
  logic        alu_zero;

  logic        setup_ph;
  logic        access_ph;
  logic        wr_acc;
  logic        addr_ok;
  logic        instr_refused;
  logic [11:0] new_instr;
  logic        is_halt;
  logic        is_sub;
  logic        is_swap;
  logic [4:0]  f_addr;
  logic        d_bit;

  // opcode match under a mask
  function automatic logic op_match(input logic [11:0] ins,
                                    input logic [11:0] pat,
                                    input logic [11:0] msk);
    op_match = ((ins & msk) == pat);
  endfunction : op_match

  // address decode for the mapped words
  function automatic logic addr_mapped(input logic [11:0] a);
    case (a)
      `SSS_ADDR_INSTR,
      `SSS_ADDR_WORK,
      `SSS_ADDR_STATUS,
      `SSS_ADDR_WATCHDOG,
      `SSS_ADDR_CTRL,
      `SSS_ADDR_FSEL,
      `SSS_ADDR_FDATA: addr_mapped = 1'b1;
      default:         addr_mapped = 1'b0;
    endcase
  endfunction : addr_mapped

  // apb phase decode
  assign setup_ph  = psel & ~penable;
  assign access_ph = psel & penable;
  assign wr_acc    = access_ph & pwrite;
  assign addr_ok   = addr_mapped(paddr);

  // instruction fields from the written word
  assign new_instr = pwdata[11:0];
  assign f_addr    = new_instr[`SSS_INSTR_F_MSB:0];
  assign d_bit     = new_instr[`SSS_INSTR_D_BIT];
  assign is_halt   = op_match(new_instr, `SSS_OP_HALT, `SSS_MASK_HALT);
  assign is_sub    = op_match(new_instr, `SSS_OP_SUB, `SSS_MASK_FD);
  assign is_swap   = op_match(new_instr, `SSS_OP_SWAP, `SSS_MASK_FD);

  // instructions are refused while the oscillator is stopped
  assign instr_refused = (r_q.state == SSS_ST_HALT) && (paddr == `SSS_ADDR_INSTR);

  // zero-wait slave, error on unmapped or refused instruction write
  assign pready  = 1'b1;
  assign pslverr = access_ph & (~addr_ok | (pwrite & instr_refused));
  assign prdata  = r_q.prdata;

  // core status pins
  assign halted  = (r_q.state == SSS_ST_HALT);
  assign osc_run = (r_q.state == SSS_ST_RUN);

  // operand fetch and operation select for the arithmetic unit
  always_comb begin
    alu_file = r_q.file[f_addr];
    if (is_sub) begin
      alu_op = SSS_OP_SUB;
    end else if (is_swap) begin
      alu_op = SSS_OP_SWAP;
    end else begin
      alu_op = SSS_OP_NONE;
    end
  end

  sss_alu u_alu (
    .op       (alu_op),
    .file_val (alu_file),
    .work_val (r_q.work),
    .result   (alu_result),
    .carry    (alu_carry),
    .digit    (alu_digit),
    .zero     (alu_zero)
  );

  // next state of the whole block
  always_comb begin
    r_d = r_q;

    // watchdog counter advances only while the oscillator runs
    if (r_q.state == SSS_ST_RUN) begin
      if (r_q.wd_pre == `SSS_WD_PRE_MAX) begin
        r_d.wd_pre = `SSS_RST_BYTE;
        r_d.wd_cnt = r_q.wd_cnt + 8'h01;
      end else begin
        r_d.wd_pre = r_q.wd_pre + 8'h01;
      end
    end

    // read data captured in the setup phase
    if (setup_ph & ~pwrite) begin
      case (paddr)
        `SSS_ADDR_INSTR:    r_d.prdata = {20'h00000, r_q.instr};
        `SSS_ADDR_WORK:     r_d.prdata = {24'h000000, r_q.work};
        `SSS_ADDR_STATUS:   r_d.prdata = {24'h000000, r_q.status};
        `SSS_ADDR_WATCHDOG: r_d.prdata = {16'h0000, r_q.wd_pre, r_q.wd_cnt};
        `SSS_ADDR_CTRL:     r_d.prdata = {31'h00000000, halted};
        `SSS_ADDR_FSEL:     r_d.prdata = {27'h0000000, r_q.fsel};
        `SSS_ADDR_FDATA:    r_d.prdata = {24'h000000, r_q.file[r_q.fsel]};
        default:            r_d.prdata = `SSS_RST_WORD;
      endcase
    end

    // register writes take effect at the access edge
    if (wr_acc) begin
      case (paddr)
        `SSS_ADDR_WORK:   r_d.work   = pwdata[7:0];
        `SSS_ADDR_STATUS: r_d.status = pwdata[7:0];
        `SSS_ADDR_FSEL:   r_d.fsel   = pwdata[4:0];
        `SSS_ADDR_FDATA:  r_d.file[r_q.fsel] = pwdata[7:0];
        `SSS_ADDR_CTRL: begin
          if (pwdata[`SSS_CTRL_HALTED] && (r_q.state == SSS_ST_HALT)) begin
            r_d.state = SSS_ST_RUN;
          end
        end
        default: begin
          r_d.prdata = r_q.prdata;
        end
      endcase
    end

    // instruction execution, one cycle per instruction
    if (wr_acc && (paddr == `SSS_ADDR_INSTR)) begin
      case (r_q.state)
        SSS_ST_RUN: begin
          r_d.instr = new_instr;
          if (is_halt) begin
            r_d.status[`SSS_ST_TIMEOUT]   = 1'b1;
            r_d.status[`SSS_ST_POWERDOWN] = 1'b0;
            r_d.status[`SSS_ST_PORT_WAKE] = r_q.status[`SSS_ST_PORT_WAKE];
            r_d.wd_cnt = `SSS_RST_BYTE;
            r_d.wd_pre = `SSS_RST_BYTE;
            r_d.state  = SSS_ST_HALT;
          end else if (is_sub) begin
            r_d.status[`SSS_ST_CARRY] = alu_carry;
            r_d.status[`SSS_ST_DIGIT] = alu_digit;
            r_d.status[`SSS_ST_ZERO]  = alu_zero;
            if (d_bit) begin
              r_d.file[f_addr] = alu_result;
            end else begin
              r_d.work = alu_result;
            end
          end else if (is_swap) begin
            if (d_bit) begin
              r_d.file[f_addr] = alu_result;
            end else begin
              r_d.work = alu_result;
            end
          end
        end
        SSS_ST_HALT: begin
          r_d.instr = r_q.instr;
        end
        default: begin
          r_d.state = SSS_ST_RUN;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_q.state  <= SSS_ST_RUN;
      r_q.instr  <= `SSS_RST_INSTR;
      r_q.work   <= `SSS_RST_BYTE;
      r_q.file   <= '0;
      r_q.status <= `SSS_RST_STATUS;
      r_q.wd_cnt <= `SSS_RST_BYTE;
      r_q.wd_pre <= `SSS_RST_BYTE;
      r_q.fsel   <= `SSS_RST_FSEL;
      r_q.prdata <= `SSS_RST_WORD;
    end else begin
      r_q <= r_d;
    end
  end

endmodule : sss_exec

/* File: hw/sss_map.svh */
`ifndef SSS_MAP_SVH
`define SSS_MAP_SVH

// register byte addresses
`define SSS_ADDR_INSTR    12'h000
`define SSS_ADDR_WORK     12'h004
`define SSS_ADDR_STATUS   12'h008
`define SSS_ADDR_WATCHDOG 12'h00c
`define SSS_ADDR_CTRL     12'h010
`define SSS_ADDR_FSEL     12'h014
`define SSS_ADDR_FDATA    12'h018

// opcode patterns and masks
`define SSS_OP_HALT       12'h003
`define SSS_MASK_HALT     12'hfff
`define SSS_OP_SUB        12'h080
`define SSS_OP_SWAP       12'h380
`define SSS_MASK_FD       12'hfc0
`define SSS_INSTR_D_BIT   5
`define SSS_INSTR_F_MSB   4

// status field positions
`define SSS_ST_CARRY      0
`define SSS_ST_DIGIT      1
`define SSS_ST_ZERO       2
`define SSS_ST_POWERDOWN  3
`define SSS_ST_TIMEOUT    4
`define SSS_ST_PORT_WAKE  7

// control field positions
`define SSS_CTRL_HALTED   0

// watchdog read layout
`define SSS_WD_CNT_LSB    0
`define SSS_WD_PRE_LSB    8

// reset values
`define SSS_RST_STATUS    8'h18
`define SSS_RST_BYTE      8'h00
`define SSS_RST_INSTR     12'h000
`define SSS_RST_WORD      32'h0000_0000
`define SSS_RST_FSEL      5'h00

// watchdog prescaler terminal count
`define SSS_WD_PRE_MAX    8'hff

`endif

/* File: hw/sss_pkg.sv */
package sss_pkg;

  // core run state, one-hot
  typedef enum logic [1:0] {
    SSS_ST_RUN  = 2'b01,
    SSS_ST_HALT = 2'b10
  } sss_state_type;

  // operation presented to the arithmetic unit
  typedef enum logic [1:0] {
    SSS_OP_NONE = 2'h0,
    SSS_OP_SUB  = 2'h1,
    SSS_OP_SWAP = 2'h2
  } sss_op_type;

  // complete state of the execution block
  typedef struct packed {
    sss_state_type   state;
    logic [11:0]     instr;
    logic [7:0]      work;
    logic [31:0][7:0] file;
    logic [7:0]      status;
    logic [7:0]      wd_cnt;
    logic [7:0]      wd_pre;
    logic [4:0]      fsel;
    logic [31:0]     prdata;
  } sss_regs_type;

endpackage : sss_pkg

/* File: hw/sss_alu.sv */
`timescale 1ns/100ps
`include "sss_map.svh"

module sss_alu (
  // operation select
  input  wire sss_pkg::sss_op_type op,
  // operands
  input  wire logic [7:0]          file_val,
  input  wire logic [7:0]          work_val,
  // result and flags
  output logic [7:0]               result,
  output logic                     carry,
  output logic                     digit,
  output logic                     zero
);
  import sss_pkg::*;

  logic [8:0] sum_full;
  logic [4:0] sum_low;

  // subtraction as file plus inverted working plus one
  assign sum_full = {1'b0, file_val} + {1'b0, ~work_val} + 9'h001;
  assign sum_low  = {1'b0, file_val[3:0]} + {1'b0, ~work_val[3:0]} + 5'h01;

  // result and flag selection
  always_comb begin
    result = file_val;
    carry  = 1'b0;
    digit  = 1'b0;
    zero   = 1'b0;
    case (op)
      SSS_OP_SUB: begin
        result = sum_full[7:0];
        carry  = sum_full[8];
        digit  = sum_low[4];
        zero   = (sum_full[7:0] == 8'h00);
      end
      SSS_OP_SWAP: begin
        result = {file_val[3:0], file_val[7:4]};
      end
      default: begin
        result = file_val;
      end
    endcase
  end

endmodule : sss_alu

/* File: test/sss_exec_assertions.sv */
`timescale 1ns/100ps
`include "sss_map.svh"

module sss_exec_assertions (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // core status
  input wire logic        halted,
  input wire logic        osc_run
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // decoded access phases
  wire acc     = psel && penable;
  wire instr_w = acc && pwrite && paddr == `SSS_ADDR_INSTR;
  wire halt_w  = instr_w && pwdata[11:0] == 12'h003;
  wire wake_w  = acc && pwrite && paddr == `SSS_ADDR_CTRL && pwdata[0];

  // read setup followed by its access cycle
  sequence s_rd(logic [11:0] a);
    psel && !penable && !pwrite && paddr == a ##1 acc;
  endsequence

  AST_HALT_ENTER: assert property (halt_w && !halted |=> halted)
    else $error("halt opcode did not stop the core");
  AST_OSC_STOP: assert property (osc_run == !halted)
    else $error("oscillator state disagrees with halt state");
  AST_HALT_HOLD: assert property (halted && !wake_w |=> halted)
    else $error("core left halt without a wake write");
  AST_WAKE: assert property (halted && wake_w |=> !halted)
    else $error("wake write did not restart the core");
  AST_HALT_REFUSE: assert property (instr_w && halted |-> pslverr)
    else $error("instruction accepted while halted");
  AST_WD_CLEAR: assert property (halted ##0 s_rd(`SSS_ADDR_WATCHDOG) |-> prdata[15:0] == 16'h0000)
    else $error("watchdog not zero in halt");
  AST_HALT_FLAGS: assert property (halt_w && !halted ##2 s_rd(`SSS_ADDR_STATUS) |-> prdata[4:3] == 2'b10)
    else $error("halt left wrong timeout or powerdown flag");
  AST_UNMAPPED: assert property (acc && paddr == 12'h01c |-> pslverr && pready)
    else $error("unmapped address not refused");
  AST_ERR_PHASE: assert property (pslverr |-> acc)
    else $error("error outside access phase");
endmodule : sss_exec_assertions

bind sss_exec sss_exec_assertions u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .halted, .osc_run);

/* File: test/sss_exec_bench.sv */
`timescale 1ns/100ps
`include "sss_map.svh"

module sss_exec_bench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, halted, osc_run;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  int          mismatches, total_checks;

  sss_exec dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .halted(halted), .osc_run(osc_run));

  // 250 mhz clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one apb transfer, bounded wait for pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (pready !== 1'b1) begin
      mismatches++;
      final_report();
    end
  endtask : apb

  // load operands, execute, then read back work, file and status
  task automatic do_op(input logic [11:0] op, input logic [7:0] fv, input logic [7:0] wv,
                       input logic [7:0] st0, input logic [7:0] er, input logic [7:0] es);
    logic [31:0] r;
    logic        e;
    apb(1'b1, `SSS_ADDR_FSEL, {27'h0, op[4:0]}, r, e);
    apb(1'b1, `SSS_ADDR_FDATA, {24'h0, fv}, r, e);
    apb(1'b1, `SSS_ADDR_WORK, {24'h0, wv}, r, e);
    apb(1'b1, `SSS_ADDR_STATUS, {24'h0, st0}, r, e);
    apb(1'b1, `SSS_ADDR_INSTR, {20'h0, op}, r, e);
    apb(1'b0, `SSS_ADDR_WORK, 32'h0, r, e);
    check(r, {24'h0, op[5] ? wv : er});
    apb(1'b0, `SSS_ADDR_FDATA, 32'h0, r, e);
    check(r, {24'h0, op[5] ? er : fv});
    apb(1'b0, `SSS_ADDR_STATUS, 32'h0, r, e);
    check(r, {24'h0, es});
  endtask : do_op

  // reset values and unmapped access
  task automatic test_reset_unmapped();
    logic [31:0] r;
    logic        e;
    apb(1'b0, `SSS_ADDR_STATUS, 32'h0, r, e);
    check(r, 32'h0000_0018);
    check({31'h0, osc_run}, 32'h0000_0001);
    check({31'h0, pready}, 32'h0000_0001);
    apb(1'b0, 12'h01c, 32'h0, r, e);
    check({31'h0, e}, 32'h0000_0001);
    check(r, 32'h0000_0000);
  endtask : test_reset_unmapped

  // positive, zero, negative and nibble-borrow differences
  task automatic test_sub();
    do_op(12'h0bf, 8'h03, 8'h02, 8'h00, 8'h01, 8'h03);
    do_op(12'h080, 8'h02, 8'h02, 8'h00, 8'h00, 8'h07);
    do_op(12'h0a5, 8'h01, 8'h02, 8'h07, 8'hff, 8'h00);
    do_op(12'h08a, 8'h10, 8'h01, 8'h00, 8'h0f, 8'h01);
  endtask : test_sub

  // both destinations, flags preset and kept
  task automatic test_swap();
    do_op(12'h39f, 8'ha5, 8'h33, 8'h85, 8'h5a, 8'h85);
    do_op(12'h3a1, 8'h0f, 8'h00, 8'h02, 8'hf0, 8'h02);
  endtask : test_swap

  // halt, refused instruction while halted, wake
  task automatic test_halt();
    logic [31:0] r;
    logic        e;
    // let the watchdog counter move off zero so that the halt clear is seen
    repeat (300) @(posedge pclk);
    apb(1'b0, `SSS_ADDR_WATCHDOG, 32'h0, r, e);
    check({31'h0, r[7:0] != 8'h00}, 32'h0000_0001);
    apb(1'b1, `SSS_ADDR_STATUS, 32'h0000_0088, r, e);
    apb(1'b1, `SSS_ADDR_INSTR, 32'h0000_0003, r, e);
    apb(1'b0, `SSS_ADDR_STATUS, 32'h0, r, e);
    check(r, 32'h0000_0090);
    apb(1'b0, `SSS_ADDR_WATCHDOG, 32'h0, r, e);
    check(r, 32'h0000_0000);
    @(negedge pclk);
    check({30'h0, halted, osc_run}, 32'h0000_0002);
    apb(1'b1, `SSS_ADDR_INSTR, 32'h0000_00a0, r, e);
    check({31'h0, e}, 32'h0000_0001);
    apb(1'b0, `SSS_ADDR_INSTR, 32'h0, r, e);
    check(r, 32'h0000_0003);
    apb(1'b0, `SSS_ADDR_CTRL, 32'h0, r, e);
    check(r, 32'h0000_0001);
    apb(1'b0, `SSS_ADDR_WATCHDOG, 32'h0, r, e);
    check(r, 32'h0000_0000);
    apb(1'b1, `SSS_ADDR_CTRL, 32'h0000_0001, r, e);
    @(negedge pclk);
    check({30'h0, halted, osc_run}, 32'h0000_0001);
  endtask : test_halt

  // reset for three cycles, then the scenarios
  initial begin
    presetn = 1'b0;
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
    mismatches = 0;
    total_checks = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    test_reset_unmapped();
    test_sub();
    test_swap();
    test_halt();
    final_report();
  end
endmodule : sss_exec_bench
